//--- pin_irq_consts.vh
// register offsets, field masks and reset values for the pin interrupt block
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef PIN_IRQ_CONSTS_VH
`define PIN_IRQ_CONSTS_VH
`define OFF_R_OD_SEL 8'h00
`define OFF_RESERVED 8'h04
`define OFF_T_IRQ_EN 8'h08
`define OFF_T_FLAGS 8'h0c
`define OFF_S_IRQ_EN 8'h10
`define OFF_S_FLAGS 8'h14
`define OFF_AD_IRQ_EN 8'h18
`define OFF_AD_FLAGS 8'h1c
`define OFF_T_POL 8'h20
`define OFF_S_POL 8'h24
`define OFF_AD_DIN_EN 8'h28
`define OFF_R_DIR 8'h2c
`define OFF_R_DATA 8'h30
`define T_FLAG_MASK 8'h60
`define S_EN_MASK 8'h60
`define S_FLAG_MASK 8'h60
`define RST_BYTE 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

//--- pin_edge_irq.v
// pin edge interrupt, wakeup flags and port r open-drain output control
// assumes pins are synchronous to aclk only after the local two-flop stage
`timescale 1ns/1ps
`include "pin_irq_consts.vh"

module pin_edge_irq (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire [7:0] port_t_pin_in,
  input wire [7:0] port_s_pin_in,
  input wire [7:0] analog_pin_in,
  output reg [7:0] port_r_pin_out,
  output reg [7:0] port_r_pin_oe_n,
  output reg irq
);

  reg [7:0] port_r_open_drain_select;
  reg [7:0] port_r_dir;
  reg [7:0] port_r_data;
  reg [7:0] port_t_irq_enable;
  reg [7:0] port_t_edge_flags;
  reg [7:0] port_s_irq_enable;
  reg [7:0] port_s_edge_flags;
  reg [7:0] analog_port_irq_enable;
  reg [7:0] analog_port_edge_flags;
  reg [7:0] port_t_edge_polarity;
  reg [7:0] port_s_edge_polarity;
  reg [7:0] analog_pin_digital_input_enable;

  // two-flop synchronisers and a third stage for edge history
  reg [7:0] t_s1, t_s2, t_s3;
  reg [7:0] s_s1, s_s2, s_s3;
  reg [7:0] a_s1, a_s2, a_s3;

  wire [7:0] t_edge;
  wire [7:0] s_edge;
  wire [7:0] a_edge;

  // axi write side
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire aw_take;
  wire w_take;
  wire wr_go;
  wire [7:0] wr_addr;
  wire [7:0] wr_byte;
  wire wr_lane0;

  assign aw_take = awvalid & awready;
  assign w_take = wvalid & wready;
  assign wr_go = (aw_held | aw_take) & (w_held | w_take) & ~bvalid;
  assign wr_addr = aw_held ? aw_addr_q : awaddr;
  assign wr_byte = w_held ? w_data_q[7:0] : wdata[7:0];
  assign wr_lane0 = w_held ? w_strb_q[0] : wstrb[0];

  // per-bit edge detectors on synchronised pins
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_edge
      assign t_edge[gi] = port_t_edge_polarity[gi] ? (t_s2[gi] & ~t_s3[gi])
                                                   : (~t_s2[gi] & t_s3[gi]);
      assign s_edge[gi] = port_s_edge_polarity[gi] ? (s_s2[gi] & ~s_s3[gi])
                                                   : (~s_s2[gi] & s_s3[gi]);
      // falling only; digital input must be enabled for the pin to be seen
      assign a_edge[gi] = ~a_s2[gi] & a_s3[gi] & analog_pin_digital_input_enable[gi];
    end
  endgenerate

  function [7:0] flag_next;
    input [7:0] cur;
    input [7:0] evt;
    input [7:0] clr;
    // set wins over a clear in the same cycle
    begin
      flag_next = (cur & ~clr) | evt;
    end
  endfunction

  wire wr_sel_t_flags;
  wire wr_sel_s_flags;
  wire wr_sel_a_flags;
  wire [7:0] t_clr;
  wire [7:0] s_clr;
  wire [7:0] a_clr;
  assign wr_sel_t_flags = wr_go & wr_lane0 & (wr_addr == `OFF_T_FLAGS);
  assign wr_sel_s_flags = wr_go & wr_lane0 & (wr_addr == `OFF_S_FLAGS);
  assign wr_sel_a_flags = wr_go & wr_lane0 & (wr_addr == `OFF_AD_FLAGS);
  assign t_clr = wr_sel_t_flags ? wr_byte : `RST_BYTE;
  assign s_clr = wr_sel_s_flags ? wr_byte : `RST_BYTE;
  assign a_clr = wr_sel_a_flags ? wr_byte : `RST_BYTE;

  wire [7:0] next_t_flags;
  wire [7:0] next_s_flags;
  wire [7:0] next_a_flags;
  assign next_t_flags = flag_next(port_t_edge_flags, t_edge, t_clr) & `T_FLAG_MASK;
  assign next_s_flags = flag_next(port_s_edge_flags, s_edge, s_clr) & `S_FLAG_MASK;
  assign next_a_flags = flag_next(analog_port_edge_flags, a_edge, a_clr);

  wire next_irq;
  assign next_irq = |(next_t_flags & port_t_irq_enable) |
                    |(next_s_flags & port_s_irq_enable) |
                    |(next_a_flags & analog_port_irq_enable);

  always @(posedge aclk) begin
    if (!aresetn) begin
      t_s1 <= `RST_BYTE;
      t_s2 <= `RST_BYTE;
      t_s3 <= `RST_BYTE;
      s_s1 <= `RST_BYTE;
      s_s2 <= `RST_BYTE;
      s_s3 <= `RST_BYTE;
      a_s1 <= `RST_BYTE;
      a_s2 <= `RST_BYTE;
      a_s3 <= `RST_BYTE;
      port_t_edge_flags <= `RST_BYTE;
      port_s_edge_flags <= `RST_BYTE;
      analog_port_edge_flags <= `RST_BYTE;
      irq <= 1'b0;
    end else begin
      t_s1 <= port_t_pin_in;
      t_s2 <= t_s1;
      t_s3 <= t_s2;
      s_s1 <= port_s_pin_in;
      s_s2 <= s_s1;
      s_s3 <= s_s2;
      a_s1 <= analog_pin_in;
      a_s2 <= a_s1;
      a_s3 <= a_s2;
      port_t_edge_flags <= next_t_flags;
      port_s_edge_flags <= next_s_flags;
      analog_port_edge_flags <= next_a_flags;
      irq <= next_irq;
    end
  end

  // note: a pin held at reset level past release gives no edge, since history resets low
  // register writes; the reserved word and unmapped addresses store nothing
  always @(posedge aclk) begin
    if (!aresetn) begin
      port_r_open_drain_select <= `RST_BYTE;
      port_r_dir <= `RST_BYTE;
      port_r_data <= `RST_BYTE;
      port_t_irq_enable <= `RST_BYTE;
      port_s_irq_enable <= `RST_BYTE;
      analog_port_irq_enable <= `RST_BYTE;
      port_t_edge_polarity <= `RST_BYTE;
      port_s_edge_polarity <= `RST_BYTE;
      analog_pin_digital_input_enable <= `RST_BYTE;
    end else if (wr_go && wr_lane0) begin
      case (wr_addr)
        `OFF_R_OD_SEL: port_r_open_drain_select <= wr_byte;
        `OFF_R_DIR: port_r_dir <= wr_byte;
        `OFF_R_DATA: port_r_data <= wr_byte;
        `OFF_T_IRQ_EN: port_t_irq_enable <= wr_byte;
        `OFF_S_IRQ_EN: port_s_irq_enable <= wr_byte & `S_EN_MASK;
        `OFF_AD_IRQ_EN: analog_port_irq_enable <= wr_byte;
        `OFF_T_POL: port_t_edge_polarity <= wr_byte;
        `OFF_S_POL: port_s_edge_polarity <= wr_byte;
        `OFF_AD_DIN_EN: analog_pin_digital_input_enable <= wr_byte;
        default: port_r_data <= port_r_data;
      endcase
    end
  end

  // port r pin drivers; oe_n low means the pin is driven
  integer k;
  reg [7:0] next_pin_out;
  reg [7:0] next_oe_n;
  always @* begin
    next_pin_out = `RST_BYTE;
    next_oe_n = 8'hff;
    for (k = 0; k < 8; k = k + 1) begin
      if (port_r_dir[k]) begin
        if (port_r_open_drain_select[k]) begin
          next_pin_out[k] = 1'b0;
          next_oe_n[k] = port_r_data[k];
        end else begin
          next_pin_out[k] = port_r_data[k];
          next_oe_n[k] = 1'b0;
        end
      end else begin
        // input pins stay released whatever the open-drain bit says
        next_oe_n[k] = 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      port_r_pin_out <= `RST_BYTE;
      port_r_pin_oe_n <= 8'hff;
    end else begin
      port_r_pin_out <= next_pin_out;
      port_r_pin_oe_n <= next_oe_n;
    end
  end

  // write channel handshake: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      awready <= ~aw_held & ~aw_take & ~bvalid & ~wr_go;
      wready <= ~w_held & ~w_take & ~bvalid & ~wr_go;
      if (aw_take && !wr_go) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (w_take && !wr_go) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wr_addr[1:0] == 2'b00 && wr_addr <= `OFF_R_DATA) ? `RESP_OKAY
                                                                 : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read channel
  reg [7:0] rd_byte;
  reg rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (araddr)
      `OFF_R_OD_SEL: rd_byte = port_r_open_drain_select;
      `OFF_RESERVED: rd_byte = `RST_BYTE;
      `OFF_T_IRQ_EN: rd_byte = port_t_irq_enable;
      `OFF_T_FLAGS: rd_byte = port_t_edge_flags;
      `OFF_S_IRQ_EN: rd_byte = port_s_irq_enable;
      `OFF_S_FLAGS: rd_byte = port_s_edge_flags;
      `OFF_AD_IRQ_EN: rd_byte = analog_port_irq_enable;
      `OFF_AD_FLAGS: rd_byte = analog_port_edge_flags;
      `OFF_T_POL: rd_byte = port_t_edge_polarity;
      `OFF_S_POL: rd_byte = port_s_edge_polarity;
      `OFF_AD_DIN_EN: rd_byte = analog_pin_digital_input_enable;
      `OFF_R_DIR: rd_byte = port_r_dir;
      `OFF_R_DATA: rd_byte = port_r_data;
      default: begin
        rd_byte = `RST_BYTE;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      arready <= ~rvalid & ~(arvalid & arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= {24'h000000, rd_byte};
        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- pin_edge_irq_checker.sv
// assertions on the ports of the pin interrupt block
// assumes it is bound onto pin_edge_irq; one clock domain
`timescale 1ns/1ps
module pin_edge_irq_checker (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready,
  input wire [7:0] port_t_pin_in,
  input wire [7:0] port_s_pin_in,
  input wire [7:0] analog_pin_in,
  input wire irq
);
  wire [23:0] pins = {port_t_pin_in, port_s_pin_in, analog_pin_in};
  wire wr = wvalid && wready;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data moved");
  a_wr_answer: assert property (awvalid && awready && wr |=> bvalid) else $error("no bvalid");
  a_rd_answer: assert property (arvalid && arready |=> rvalid) else $error("no rvalid");
  a_busy_refuse: assert property (bvalid |-> !awready && !wready) else $error("took write");
  a_ar_refuse: assert property (rvalid |-> !arready) else $error("took read");
  a_reserved_zero: assert property (arvalid && arready && araddr == 8'h04 |=>
    rdata == 32'h0 && rresp == 2'b00) else $error("reserved not zero");
  // a rise of irq needs a synchronised pin change or a register write behind it
  a_irq_cause: assert property ($rose(irq) |->
    $past(pins, 2) != $past(pins, 3) || $past(pins, 3) != $past(pins, 4) ||
    $past(wr) || $past(wr, 2) || $past(wr, 3)) else $error("irq without cause");
endmodule
bind pin_edge_irq pin_edge_irq_checker chk_u (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready), .port_t_pin_in(port_t_pin_in),
  .port_s_pin_in(port_s_pin_in), .analog_pin_in(analog_pin_in), .irq(irq));

//--- pin_side_model.sv
// external pins: drivers for ports t, s, analog and the port r wire
// assumes the bench sets targets; frontplane drive stays off
`timescale 1ns/1ps
module pin_side_model (
  input wire aclk,
  input wire [23:0] target,
  input wire [7:0] r_out,
  input wire [7:0] r_oe_n,
  output reg [23:0] pins,
  output wire [7:0] r_wire
);
  initial pins = 24'h0;
  // pins move just after an edge of aclk, so the block first samples them on the next edge
  always @(posedge aclk) begin
    pins <= target;
  end
  // a released bit floats up to the pull-up level
  assign r_wire = (~r_oe_n & r_out) | r_oe_n;
endmodule

//--- tb_pin_edge_irq.sv
// self-checking bench for pin_edge_irq over axi4-lite
// assumes the offsets of pin_irq_consts.vh and pin_side_model on the pins
`timescale 1ns/1ps
`include "pin_irq_consts.vh"
module tb_pin_edge_irq;
  reg aclk = 0;
  reg aresetn = 0;
  reg [7:0] awaddr = 0, araddr = 0;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [31:0] wdata = 0, seed = 32'h4c0c, rd, resp;
  reg [23:0] target = 0, nw = 0, old;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [23:0] pins;
  wire [7:0] r_out, r_oe_n, r_wire;
  integer n_errors = 0, samples_checked = 0, i;
  reg [7:0] et, es, ea, pt, ps, din, ft, fs, fa, dir, dv, od;
  always #2 aclk = ~aclk;
  pin_edge_irq dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .port_t_pin_in(pins[23:16]),
    .port_s_pin_in(pins[15:8]), .analog_pin_in(pins[7:0]), .port_r_pin_out(r_out),
    .port_r_pin_oe_n(r_oe_n), .irq(irq));
  pin_side_model pin_u (.aclk(aclk), .target(target), .r_out(r_out), .r_oe_n(r_oe_n),
    .pins(pins), .r_wire(r_wire));
  function [31:0] xs(input [31:0] x);
    xs = x ^ (x << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  function [7:0] edg(input [7:0] o, input [7:0] n, input [7:0] p);
    edg = (~o & n & p) | (o & ~n & ~p);
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] g);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("BAD %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    // no cycle count is assumed: only the watchdog ends a wait
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) ad = 1;
      if (ad) awvalid <= 0;
      if (wvalid && wready) wd = 1;
      if (wd) wvalid <= 0;
    end
    bready <= 1;
    while (!bvalid) @(posedge aclk);
    resp = {30'h0, bresp};
    bready <= 0;
  endtask
  task rd_(input [7:0] a);
    araddr <= a;
    arvalid <= 1;
    // let one edge pass so arvalid is really seen before it can drop
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 0;
    rready <= 1;
    @(posedge aclk);
    while (!rvalid) @(posedge aclk);
    rd = rdata;
    resp = {30'h0, rresp};
    rready <= 0;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #80000;
    n_errors = n_errors + 1;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (i = 0; i < 52; i = i + 4) begin
      rd_(i);
      chk("reset value", 0, rd);
    end
    wr(`OFF_RESERVED, 8'hff);
    chk("reserved bresp", `RESP_OKAY, resp);
    wr(8'h34, 8'hff);
    chk("unmapped bresp", `RESP_SLVERR, resp);
    rd_(`OFF_RESERVED);
    chk("reserved", 0, rd | resp);
    rd_(8'h34);
    chk("unmapped resp", `RESP_SLVERR, resp);
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      {od, dv, dir} = seed[23:0];
      if (i < 2) od = {8{i == 0}};
      wr(`OFF_R_DIR, dir);
      wr(`OFF_R_DATA, dv);
      wr(`OFF_R_OD_SEL, od);
      @(posedge aclk);
      chk("oe_n", {24'h0, ~dir | (od & dv)}, r_oe_n);
      chk("r wire", {24'h0, ~dir | dv}, r_wire);
    end
    // set while analog pins are low, so the gate change makes no edge
    din = seed[31:24];
    wr(`OFF_AD_DIN_EN, din);
    {ft, fs, fa} = 0;
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      {pt, ea, es, et} = seed;
      seed = xs(seed);
      ps = seed[7:0];
      wr(`OFF_T_IRQ_EN, et);
      wr(`OFF_S_IRQ_EN, es);
      wr(`OFF_AD_IRQ_EN, ea);
      wr(`OFF_T_POL, pt);
      wr(`OFF_S_POL, ps);
      es = es & `S_EN_MASK;
      rd_(`OFF_T_IRQ_EN);
      chk("t enable", et, rd);
      rd_(`OFF_S_IRQ_EN);
      chk("s enable", es, rd);
      rd_(`OFF_AD_IRQ_EN);
      chk("ad enable", ea, rd);
      old = nw;
      nw = (i == 0) ? ~old : seed[31:8];
      target <= nw;
      repeat (8) @(posedge aclk);
      ft = ft | (edg(old[23:16], nw[23:16], pt) & `T_FLAG_MASK);
      fs = fs | (edg(old[15:8], nw[15:8], ps) & `S_FLAG_MASK);
      fa = fa | (edg(old[7:0], nw[7:0], 8'h00) & din);
      rd_(`OFF_T_FLAGS);
      chk("t flags", ft, rd);
      rd_(`OFF_S_FLAGS);
      chk("s flags", fs, rd);
      rd_(`OFF_AD_FLAGS);
      chk("ad flags", fa, rd);
      chk("irq", |{ft & et, fs & es, fa & ea}, irq);
      seed = xs(seed);
      wr(`OFF_T_FLAGS, seed[7:0]);
      wr(`OFF_S_FLAGS, seed[15:8]);
      wr(`OFF_AD_FLAGS, seed[23:16]);
      {fa, fs, ft} = {fa, fs, ft} & ~seed[23:0];
      repeat (2) @(posedge aclk);
      chk("irq clear", |{ft & et, fs & es, fa & ea}, irq);
    end
    complete_run;
  end
endmodule
